// ---- include/relay_regs.vh ----
// Overview of operation
// [R1] A relay whose force-mask bit is 1 is driven by its forced-value bit.
// [R2] Reset (boot or power cycle) clears the force mask and forced values.
// [R3] Bits 0, 1 and 2 of both force registers serve relays one to three.
// [R4] A force-mask bit of 0 lets the relay follow its selected source.
// [R5] Selector code 0 de-energizes relay one and code 1 energizes it.
// [R6] Selector code 2 follows ready-to-run, main status bit 1.
// [R7] Codes 4, 5 and 7 follow bits 0, 5 and 6 of drive status word one.
// [R8] Codes 6 and 12 follow bits 1 and 10 of drive status word two.
// [R9] Codes 8 and 9 follow main status bits 2 and 8.
// [R10] Codes 10 and 11 follow speed status bits 2 and 0.
// [R11] Codes 13 and 14 follow main status bits 7 (warning) and 3 (fault).
// [R12] Code 15 follows the inverse of main status bit 3.
// [R13] Code 16 follows main status bit 3 OR bit 7.
// [R14] Codes 17 and 18 follow the overcurrent and overvoltage fault events.
// [R15] After reset the relay-one selector holds code 2.
// [R16] Outputs are registered every cycle, mux then force; other codes are 0.
`ifndef RELAY_REGS_VH
`define RELAY_REGS_VH

// Register byte offsets on the APB bus.
`define RELAY_FORCE_MASK_OFS   8'h00
`define RELAY_FORCE_VALUES_OFS 8'h04
`define RELAY_ONE_SEL_OFS      8'h08
`define RELAY_STATUS_OFS       8'h0C
`define RELAY_SOURCE_OFS       8'h10
`define RELAY_MAIN_STAT_OFS    8'h14
`define RELAY_DRV_STAT1_OFS    8'h18
`define RELAY_DRV_STAT2_OFS    8'h1C
`define RELAY_SPD_STAT_OFS     8'h20

// Field layout and reset values.
`define RELAY_COUNT            3
`define RELAY_SEL_W            8
`define RELAY_FORCE_RST        3'h0
`define RELAY_SEL_RST          8'h02

// Relay-one selector codes.
`define SEL_OFF                8'h00
`define SEL_ON                 8'h01
`define SEL_READY_RUN          8'h02
`define SEL_ENABLED            8'h04
`define SEL_STARTED            8'h05
`define SEL_MAGNETIZED         8'h06
`define SEL_RUNNING            8'h07
`define SEL_READY_REF          8'h08
`define SEL_AT_SETPOINT        8'h09
`define SEL_REVERSE            8'h0A
`define SEL_ZERO_SPEED         8'h0B
`define SEL_ABOVE_LIMIT        8'h0C
`define SEL_WARNING            8'h0D
`define SEL_FAULT              8'h0E
`define SEL_FAULT_INV          8'h0F
`define SEL_FAULT_OR_WARN      8'h10
`define SEL_OVERCURRENT        8'h11
`define SEL_OVERVOLTAGE        8'h12

// Status bit positions.
`define MAIN_READY_RUN_BIT     1
`define MAIN_READY_REF_BIT     2
`define MAIN_FAULT_BIT         3
`define MAIN_WARNING_BIT       7
`define MAIN_AT_SETPOINT_BIT   8
`define DRV1_ENABLED_BIT       0
`define DRV1_STARTED_BIT       5
`define DRV1_RUNNING_BIT       6
`define DRV2_MAGNETIZED_BIT    1
`define DRV2_ABOVE_LIMIT_BIT   10
`define SPD_ZERO_SPEED_BIT     0
`define SPD_REVERSE_BIT        2

`endif

// ---- rtl/relay_source_mux.v ----
`include "relay_regs.vh"

module relay_source_mux #(
  parameter SEL_W = `RELAY_SEL_W
) (
  // Selector
  input  wire [SEL_W-1:0] selector_in,
  // Drive status
  input  wire [15:0]      main_status_in,
  input  wire [15:0]      drive_status_one_in,
  input  wire [15:0]      drive_status_two_in,
  input  wire [15:0]      speed_status_in,
  input  wire             overcurrent_fault_in,
  input  wire             overvoltage_fault_in,
  // Selected level
  output reg              source_level_out
);

  always @* begin
    case (selector_in)
      `SEL_OFF:           source_level_out = 1'b0; // [R5]
      `SEL_ON:            source_level_out = 1'b1; // [R5]
      `SEL_READY_RUN:
        source_level_out = main_status_in[`MAIN_READY_RUN_BIT]; // [R6]
      `SEL_ENABLED:
        source_level_out = drive_status_one_in[`DRV1_ENABLED_BIT]; // [R7]
      `SEL_STARTED:
        source_level_out = drive_status_one_in[`DRV1_STARTED_BIT]; // [R7]
      `SEL_RUNNING:
        source_level_out = drive_status_one_in[`DRV1_RUNNING_BIT]; // [R7]
      `SEL_MAGNETIZED:
        source_level_out = drive_status_two_in[`DRV2_MAGNETIZED_BIT]; // [R8]
      `SEL_ABOVE_LIMIT:
        source_level_out = drive_status_two_in[`DRV2_ABOVE_LIMIT_BIT]; // [R8]
      `SEL_READY_REF:
        source_level_out = main_status_in[`MAIN_READY_REF_BIT]; // [R9]
      `SEL_AT_SETPOINT:
        source_level_out = main_status_in[`MAIN_AT_SETPOINT_BIT]; // [R9]
      `SEL_REVERSE:
        source_level_out = speed_status_in[`SPD_REVERSE_BIT]; // [R10]
      `SEL_ZERO_SPEED:
        source_level_out = speed_status_in[`SPD_ZERO_SPEED_BIT]; // [R10]
      `SEL_WARNING:
        source_level_out = main_status_in[`MAIN_WARNING_BIT]; // [R11]
      `SEL_FAULT:
        source_level_out = main_status_in[`MAIN_FAULT_BIT]; // [R11]
      `SEL_FAULT_INV:
        source_level_out = ~main_status_in[`MAIN_FAULT_BIT]; // [R12]
      `SEL_FAULT_OR_WARN:
        source_level_out = main_status_in[`MAIN_FAULT_BIT] |
                           main_status_in[`MAIN_WARNING_BIT]; // [R13]
      `SEL_OVERCURRENT:   source_level_out = overcurrent_fault_in; // [R14]
      `SEL_OVERVOLTAGE:   source_level_out = overvoltage_fault_in; // [R14]
      // Codes without a wired source fail safe to de-energized.
      default:            source_level_out = 1'b0; // [R16]
    endcase
  end

endmodule

// ---- rtl/relay_output_ctrl.v ----
// Our own choices: the register addresses and the APB interface to the registers.
`include "relay_regs.vh"

module relay_output_ctrl #(
  parameter ADDR_W = 8,
  parameter SEL_W  = `RELAY_SEL_W
) (
  // Clock and reset
  input  wire              clk_sys_in,
  input  wire              rst_in,
  // APB slave
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [ADDR_W-1:0] paddr_in,
  input  wire [31:0]       pwdata_in,
  input  wire [3:0]        pstrb_in,
  output wire              pready_out,
  output wire              pslverr_out,
  output wire [31:0]       prdata_out,
  // Drive status flags
  input  wire [15:0]       main_status_in,
  input  wire [15:0]       drive_status_one_in,
  input  wire [15:0]       drive_status_two_in,
  input  wire [15:0]       speed_status_in,
  input  wire              overcurrent_fault_in,
  input  wire              overvoltage_fault_in,
  // Sources of relays two and three
  input  wire              relay_two_source_in,
  input  wire              relay_three_source_in,
  // Relay energize outputs
  output wire              relay_out_one_out,
  output wire              relay_out_two_out,
  output wire              relay_out_three_out
);

  localparam NR = `RELAY_COUNT;

  // Software state.
  reg  [NR-1:0]    relay_force_mask_q;
  reg  [NR-1:0]    relay_force_values_q;
  reg  [SEL_W-1:0] relay_one_selector_q;
  // Relay drive state.
  reg  [NR-1:0]    relay_q;
  reg  [NR-1:0]    relay_d;
  // Bus read data.
  reg  [31:0]      prdata_q;
  reg  [31:0]      prdata_d;
  reg              pslverr_q;
  reg              pslverr_d;

  wire             relay_one_source;
  wire [NR-1:0]    source_vec;
  wire             bus_setup;
  wire             bus_write;
  wire             mask_wr;
  wire             values_wr;
  wire             sel_wr;
  wire [31:0]      mask_merge;
  wire [31:0]      values_merge;
  wire [31:0]      sel_merge;

  // Returns 1 when the address names a mapped register.
  function addr_mapped;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `RELAY_FORCE_MASK_OFS,
        `RELAY_FORCE_VALUES_OFS,
        `RELAY_ONE_SEL_OFS,
        `RELAY_STATUS_OFS,
        `RELAY_SOURCE_OFS,
        `RELAY_MAIN_STAT_OFS,
        `RELAY_DRV_STAT1_OFS,
        `RELAY_DRV_STAT2_OFS,
        `RELAY_SPD_STAT_OFS: addr_mapped = 1'b1;
        default:             addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // Returns 1 when the address names a register that software may write.
  function addr_writable;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `RELAY_FORCE_MASK_OFS,
        `RELAY_FORCE_VALUES_OFS,
        `RELAY_ONE_SEL_OFS: addr_writable = 1'b1;
        default:            addr_writable = 1'b0;
      endcase
    end
  endfunction

  // Merges the enabled byte lanes of a write into an old value.
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Zero-extends a relay bit vector to a bus word.
  function [31:0] relay_word;
    input [NR-1:0] bits;
    begin
      relay_word = 32'h0000_0000;
      relay_word[NR-1:0] = bits;
    end
  endfunction

  // Zero-extends a selector code to a bus word.
  function [31:0] sel_word;
    input [SEL_W-1:0] code;
    begin
      sel_word = 32'h0000_0000;
      sel_word[SEL_W-1:0] = code;
    end
  endfunction

  // Zero-extends a status word to a bus word.
  function [31:0] status_word;
    input [15:0] flags;
    begin
      status_word = {16'h0000, flags};
    end
  endfunction

  // Returns 1 for an unmapped address or a write to a read-only register.
  function bus_error;
    input [ADDR_W-1:0] addr;
    input              write;
    begin
      bus_error = ~addr_mapped(addr) | (write & ~addr_writable(addr));
    end
  endfunction

  // Relay-one source selection.
  relay_source_mux #(
    .SEL_W                (SEL_W)
  ) u_source_mux (
    .selector_in          (relay_one_selector_q),
    .main_status_in       (main_status_in),
    .drive_status_one_in  (drive_status_one_in),
    .drive_status_two_in  (drive_status_two_in),
    .speed_status_in      (speed_status_in),
    .overcurrent_fault_in (overcurrent_fault_in),
    .overvoltage_fault_in (overvoltage_fault_in),
    .source_level_out     (relay_one_source)
  );

  // Bit 0 is relay one, bit 1 relay two, bit 2 relay three.
  assign source_vec = {relay_three_source_in,
                       relay_two_source_in,
                       relay_one_source}; // [R3]

  // The bus has no wait states: read data is staged in the setup cycle.
  assign bus_setup = psel_in & ~penable_in;
  assign bus_write = psel_in & penable_in & pwrite_in &
                     addr_writable(paddr_in);

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & pslverr_q;
  assign prdata_out  = prdata_q;

  // Per-register write strobes; enabled byte lanes merge into the old value.
  assign mask_wr      = bus_write & (paddr_in == `RELAY_FORCE_MASK_OFS);
  assign values_wr    = bus_write & (paddr_in == `RELAY_FORCE_VALUES_OFS);
  assign sel_wr       = bus_write & (paddr_in == `RELAY_ONE_SEL_OFS);
  assign mask_merge   = lane_merge(relay_word(relay_force_mask_q),
                                   pwdata_in, pstrb_in);
  assign values_merge = lane_merge(relay_word(relay_force_values_q),
                                   pwdata_in, pstrb_in);
  assign sel_merge    = lane_merge(sel_word(relay_one_selector_q),
                                   pwdata_in, pstrb_in);

  // Force registers. Reserved bits 3 to 31 are not stored and read as zero.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      relay_force_mask_q   <= `RELAY_FORCE_RST; // [R2]
      relay_force_values_q <= `RELAY_FORCE_RST; // [R2]
    end else begin
      if (mask_wr) begin
        relay_force_mask_q <= mask_merge[NR-1:0]; // [R3]
      end
      if (values_wr) begin
        relay_force_values_q <= values_merge[NR-1:0]; // [R3]
      end
    end
  end

  // Relay-one selector.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      relay_one_selector_q <= `RELAY_SEL_RST; // [R15]
    end else if (sel_wr) begin
      relay_one_selector_q <= sel_merge[SEL_W-1:0];
    end
  end

  // Per relay: the force bit wins, otherwise the selected source drives.
  always @* begin : relay_next
    integer k;
    k       = 0;
    relay_d = {NR{1'b0}};
    for (k = 0; k < NR; k = k + 1) begin
      if (relay_force_mask_q[k]) begin
        relay_d[k] = relay_force_values_q[k]; // [R1]
      end else begin
        relay_d[k] = source_vec[k]; // [R4]
      end
    end
  end

  // Registered every cycle so the relay drivers never see mux glitches.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      relay_q <= {NR{1'b0}};
    end else begin
      relay_q <= relay_d; // [R16]
    end
  end

  assign relay_out_one_out   = relay_q[0];
  assign relay_out_two_out   = relay_q[1];
  assign relay_out_three_out = relay_q[2];

  // Read data and error staging for the coming access phase.
  always @* begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (bus_setup) begin
      pslverr_d = bus_error(paddr_in, pwrite_in);
      case (paddr_in)
        `RELAY_FORCE_MASK_OFS:
          prdata_d = relay_word(relay_force_mask_q);
        `RELAY_FORCE_VALUES_OFS:
          prdata_d = relay_word(relay_force_values_q);
        `RELAY_ONE_SEL_OFS:
          prdata_d = sel_word(relay_one_selector_q);
        `RELAY_STATUS_OFS:
          prdata_d = relay_word(relay_q);
        `RELAY_SOURCE_OFS:
          prdata_d = relay_word(source_vec);
        `RELAY_MAIN_STAT_OFS:
          prdata_d = status_word(main_status_in);
        `RELAY_DRV_STAT1_OFS:
          prdata_d = status_word(drive_status_one_in);
        `RELAY_DRV_STAT2_OFS:
          prdata_d = status_word(drive_status_two_in);
        `RELAY_SPD_STAT_OFS:
          prdata_d = status_word(speed_status_in);
        default:
          prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

endmodule

// ---- verification/relay_output_checker.sv ----
module relay_output_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic        pready_out,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [15:0] main_status_in,
  input wire logic        relay_two_source_in,
  input wire logic        relay_three_source_in,
  input wire logic        relay_out_one_out,
  input wire logic        relay_out_two_out,
  input wire logic        relay_out_three_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow registers rebuilt from bus writes, so no internal probe is needed.
  logic [2:0] fm_q;
  logic [2:0] fv_q;
  logic [7:0] sel_q;
  logic       live_q;
  wire        wr = psel_in && penable_in && pwrite_in && pready_out;
  wire        wl = wr && pstrb_in[0];
  wire [8:0]  s1 = {fm_q[0], sel_q};
  wire        e2 = fm_q[1] ? fv_q[1] : relay_two_source_in;
  wire        e3 = fm_q[2] ? fv_q[2] : relay_three_source_in;
  always_ff @(posedge clk_sys_in) begin
    live_q <= !rst_in;
    if (rst_in) begin
      fm_q <= 3'h0;
      fv_q <= 3'h0;
      sel_q <= 8'h02;
    end else if (wl && paddr_in == 8'h00) begin
      fm_q <= pwdata_in[2:0];
    end else if (wl && paddr_in == 8'h04) begin
      fv_q <= pwdata_in[2:0];
    end else if (wl && paddr_in == 8'h08) begin
      sel_q <= pwdata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  reset_clear_a: assert property (disable iff (1'b0)
    rst_in |=> !relay_out_one_out && !relay_out_two_out && !relay_out_three_out)
    else $error("relay not cleared by reset");
  relay_two_a: assert property (
    live_q |-> relay_out_two_out == $past(e2)) else $error("relay two wrong");
  relay_three_a: assert property (
    live_q |-> relay_out_three_out == $past(e3))
    else $error("relay three wrong");
  forced_one_a: assert property (live_q && $past(fm_q[0])
    |-> relay_out_one_out == $past(fv_q[0])) else $error("relay one force");
  off_on_a: assert property (live_q && $past(s1) < 9'h002
    |-> relay_out_one_out == $past(sel_q[0])) else $error("fixed code");
  ready_run_a: assert property (live_q && $past(s1) == 9'h002
    |-> relay_out_one_out == $past(main_status_in[1])) else $error("ready");
  fault_inv_a: assert property (live_q && $past(s1) == 9'h00F
    |-> relay_out_one_out != $past(main_status_in[3])) else $error("inv");
  fault_warn_a: assert property (live_q && $past(s1) == 9'h010
    |-> relay_out_one_out == ($past(main_status_in[3])
    | $past(main_status_in[7]))) else $error("fault or warning");
  unused_sel_a: assert property (live_q && ($past(s1) == 9'h003
    || ($past(s1) > 9'h012 && $past(s1) < 9'h100)) |-> !relay_out_one_out)
    else $error("unlisted code");
endmodule

// ---- verification/status_model.sv ----
module status_model (
  input  wire logic        clk_sys_in,
  input  wire logic        load_in,
  input  wire logic [31:0] data_in,
  output logic      [15:0] main_out = 16'h0000,
  output logic      [15:0] one_out = 16'h0000,
  output logic      [15:0] two_out = 16'h0000,
  output logic      [15:0] spd_out = 16'h0000,
  output logic             oc_out = 1'b0,
  output logic             ov_out = 1'b0,
  output logic             src2_out = 1'b0,
  output logic             src3_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flags change only on a load, as drive status words do between updates.
  always @(posedge clk_sys_in) begin
    if (load_in) begin
      main_out <= data_in[15:0];
      one_out <= data_in[31:16];
      two_out <= ~data_in[15:0];
      spd_out <= data_in[23:8];
      oc_out <= data_in[0] ^ data_in[9];
      ov_out <= data_in[3] ^ data_in[20];
      src2_out <= data_in[11];
      src3_out <= data_in[29];
    end
  end
endmodule

// ---- verification/relay_output_select_force_tb.sv ----
module relay_output_select_force_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0, rst_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, ld = 0, pready_out, pslverr_out, x1, x2, x3;
  logic relay_out_one_out, relay_out_two_out, relay_out_three_out;
  logic overcurrent_fault_in, overvoltage_fault_in;
  logic relay_two_source_in, relay_three_source_in;
  logic [7:0] paddr_in = 8'h00;
  logic [3:0] pstrb_in = 4'h0;
  logic [31:0] pwdata_in = 32'h0000_0000, dat = 32'h0000_0000, r, prdata_out;
  logic [31:0] rs = 32'hc2a7_a337;
  logic [15:0] main_status_in, drive_status_one_in;
  logic [15:0] drive_status_two_in, speed_status_in;
  logic [32:0] q[$];
  logic [32:0] e;
  int err_total = 0, check_count = 0, cyc = 0;
  relay_output_ctrl u_relay_output_ctrl (.clk_sys_in, .rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .pready_out,
    .pslverr_out, .prdata_out, .main_status_in, .drive_status_one_in,
    .drive_status_two_in, .speed_status_in, .overcurrent_fault_in,
    .overvoltage_fault_in, .relay_two_source_in, .relay_three_source_in,
    .relay_out_one_out, .relay_out_two_out, .relay_out_three_out);
  status_model u_status_model (.clk_sys_in, .load_in(ld), .data_in(dat),
    .main_out(main_status_in), .one_out(drive_status_one_in),
    .two_out(drive_status_two_in), .spd_out(speed_status_in),
    .oc_out(overcurrent_fault_in), .ov_out(overvoltage_fault_in),
    .src2_out(relay_two_source_in), .src3_out(relay_three_source_in));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic f1(input logic [7:0] c);
    logic [15:0] m;
    m = main_status_in;
    case (c)
      8'h01: return 1'b1;
      8'h02: return m[1];
      8'h04: return drive_status_one_in[0];
      8'h05: return drive_status_one_in[5];
      8'h06: return drive_status_two_in[1];
      8'h07: return drive_status_one_in[6];
      8'h08: return m[2];
      8'h09: return m[8];
      8'h0A: return speed_status_in[2];
      8'h0B: return speed_status_in[0];
      8'h0C: return drive_status_two_in[10];
      8'h0D: return m[7];
      8'h0E: return m[3];
      8'h0F: return !m[3];
      8'h10: return m[3] | m[7];
      8'h11: return overcurrent_fault_in;
      8'h12: return overvoltage_fault_in;
      default: return 1'b0;
    endcase
  endfunction
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [32:0] x);
    @(posedge clk_sys_in);
    q.push_back(x);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic load();
    @(posedge clk_sys_in);
    ld <= 1'b1;
    dat <= xs();
    @(posedge clk_sys_in);
    ld <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic chk_rst();
    apb(0, 8'h00, 32'h0000_0000, 4'h0, 33'h0_0000_0000);
    apb(0, 8'h04, 32'h0000_0000, 4'h0, 33'h0_0000_0000);
    apb(0, 8'h08, 32'h0000_0000, 4'h0, 33'h0_0000_0002);
    apb(0, 8'h0C, 32'h0000_0000, 4'h0, {30'h0000_0000, relay_three_source_in,
      relay_two_source_in, main_status_in[1]});
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      end_of_test();
    end
    if (psel_in && penable_in && pready_out === 1'b1) begin
      e = q.pop_front();
      check_count++;
      if (pslverr_out !== e[32] || (!pwrite_in && prdata_out !== e[31:0]))
      begin
        err_total++;
        $display("mismatch apb %h exp %h seen %h", paddr_in, e,
          {pslverr_out, prdata_out});
      end
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    chk_rst();
    apb(1, 8'h0C, 32'h0000_0001, 4'hF, 33'h1_0000_0000);
    apb(0, 8'h40, 32'h0000_0000, 4'h0, 33'h1_0000_0000);
    // Codes 3, 19 and 20 lie in the gaps and must read as de-energized.
    for (int c = 0; c < 21; c++) begin
      apb(1, 8'h08, c, 4'hF, 33'h0_0000_0000);
      for (int j = 0; j < 4; j++) begin
        r = xs();
        apb(1, 8'h00, r, 4'hF, 33'h0_0000_0000);
        apb(0, 8'h00, 32'h0000_0000, 4'h0, {30'h0, r[2:0]});
        apb(1, 8'h04, r >> 3, 4'hF, 33'h0_0000_0000);
        load();
        x1 = r[0] ? r[3] : f1(c);
        x2 = r[1] ? r[4] : relay_two_source_in;
        x3 = r[2] ? r[5] : relay_three_source_in;
        apb(0, 8'h0C, r, 4'h0, {30'h0, x3, x2, x1});
      end
    end
    apb(1, 8'h08, 32'h0000_0005, 4'hE, 33'h0_0000_0000);
    apb(0, 8'h08, 32'h0000_0000, 4'h0, 33'h0_0000_0014);
    apb(1, 8'h00, 32'h0000_0007, 4'hF, 33'h0_0000_0000);
    apb(1, 8'h04, 32'h0000_0007, 4'hF, 33'h0_0000_0000);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    chk_rst();
    end_of_test();
  end
endmodule
bind relay_output_ctrl relay_output_checker u_relay_output_checker (
  .clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .pready_out,
  .paddr_in, .pwdata_in, .pstrb_in, .main_status_in, .relay_two_source_in,
  .relay_three_source_in, .relay_out_one_out, .relay_out_two_out,
  .relay_out_three_out);
